// ===== design/brg_rate_gen.sv
// Serial port rate generator: divisor register and free-running rate timer
//
// Behaviour
// [RQ1] One 8-bit timer serves both modes
// [RQ2] Timer free-runs; divisor register sets period
// [RQ3] Async: high-speed bit selects period multiplier
// [RQ4] Sync mode ignores the high-speed bit
// [RQ5] Rate is clock over 64/16/4 times n+1
// [RQ6] Divisor write clears the timer at once
// [RQ7] Software should prefer high speed when closer
// [RQ8] Counter reloads after n+1 prescaled counts, ticks
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module brg_rate_gen
  import brg_pkg::*;
(
  input  wire logic       CLOCK_I,
  input  wire logic       RST_I,
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  output logic            SYNC_MODE_O,
  output logic            RATE_TICK_O
);

  brg_bus_s   bus;
  logic [7:0] rcv_ctl;
  logic [7:0] divisor;
  logic [7:0] xmt_ctl;
  logic [5:0] pre_cnt;
  logic [7:0] rate_timer;
  logic [7:0] tick_count;
  logic [5:0] pre_limit;
  logic       pre_end;
  logic       div_wr;
  brg_mode_e  mode;

  assign bus    = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign div_wr = bus.wr && (bus.addr == BRG_ADDR_DIVISOR);

  // Registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rcv_ctl <= BRG_RST_RCV_CTL;
      divisor <= BRG_RST_DIVISOR;
      xmt_ctl <= BRG_RST_XMT_CTL;
    end else if (bus.wr) begin
      unique case (bus.addr)
        BRG_ADDR_RCV_CTL: rcv_ctl <= bus.wdata;
        BRG_ADDR_DIVISOR: divisor <= bus.wdata; // RQ2
        BRG_ADDR_XMT_CTL: begin
          // Shift-register status bit belongs to the transmitter; kept at reset value
          xmt_ctl <= {bus.wdata[7:4], 1'b0, bus.wdata[2], BRG_RST_XMT_CTL[1], bus.wdata[0]};
        end
        BRG_ADDR_TICKCNT: ;
      endcase
    end
  end

  // Mode select
  always_comb begin
    if (xmt_ctl[BRG_XMT_SYNC_BIT]) begin
      mode = BRG_MODE_SYNC; // RQ4
    end else if (xmt_ctl[BRG_XMT_HS_BIT]) begin
      mode = BRG_MODE_ASYNC_HIGH; // RQ3
    end else begin
      mode = BRG_MODE_ASYNC_LOW; // RQ3
    end
  end

  always_comb begin
    unique case (mode)
      BRG_MODE_SYNC:       pre_limit = BRG_PRE_SYNC; // RQ5
      BRG_MODE_ASYNC_HIGH: pre_limit = BRG_PRE_ASYNC_HIGH; // RQ5
      default:             pre_limit = BRG_PRE_ASYNC_LOW; // RQ5
    endcase
  end

  assign pre_end = (pre_cnt >= pre_limit);

  // Prescaler; a mode change mid-period ends the current step at the new limit, at once if the count is already past it
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pre_cnt <= 6'h00;
    end else if (div_wr || pre_end) begin
      pre_cnt <= 6'h00; // RQ6
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // Rate timer counts down from n, reloads and ticks at zero
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rate_timer  <= 8'h00;
      RATE_TICK_O <= 1'b0;
    end else if (div_wr) begin
      rate_timer  <= bus.wdata; // RQ6
      RATE_TICK_O <= 1'b0;
    end else if (pre_end) begin
      RATE_TICK_O <= (rate_timer == 8'h00); // RQ8
      rate_timer  <= (rate_timer == 8'h00) ? divisor : rate_timer - 8'h01; // RQ1 RQ2 RQ8
    end else begin
      RATE_TICK_O <= 1'b0;
    end
  end

  // Status: ticks seen, wraps freely
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_count <= 8'h00;
    end else if (RATE_TICK_O) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        BRG_ADDR_RCV_CTL: RDATA_O <= rcv_ctl;
        BRG_ADDR_DIVISOR: RDATA_O <= divisor;
        BRG_ADDR_XMT_CTL: RDATA_O <= xmt_ctl;
        BRG_ADDR_TICKCNT: RDATA_O <= tick_count;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  assign SYNC_MODE_O = xmt_ctl[BRG_XMT_SYNC_BIT];

  // Check-only helpers; none of them feeds an output
  // Live rises one edge after reset ends, so no check starts on the release edge
  logic        live;
  logic        settled;
  logic        xmt_wr;
  logic [15:0] gap;
  logic [15:0] period;

  assign xmt_wr = bus.wr && (bus.addr == BRG_ADDR_XMT_CTL);
  assign period = 16'({8'h00, divisor} + 16'h0001) * 16'({10'h000, pre_limit} + 16'h0001);

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end

  // Cycles into the running period; a divisor write starts a fresh one
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      gap <= 16'h0000;
    end else if (div_wr) begin
      gap <= 16'h0000;
    end else if (RATE_TICK_O) begin
      gap <= 16'h0001;
    end else begin
      gap <= gap + 16'h0001;
    end
  end

  // A mode change bends the running period, so that period is not judged
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      settled <= 1'b1;
    end else if (xmt_wr) begin
      settled <= 1'b0;
    end else if (div_wr || RATE_TICK_O) begin
      settled <= 1'b1;
    end
  end

  tick_period_a: assert property ( // RQ5
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (RATE_TICK_O && settled) |-> (gap == period)
  ) else begin
    $error("tick period wrong");
  end

  tick_spacing_a: assert property ( // RQ8
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (RATE_TICK_O && !$past(div_wr)) |-> ##1 !RATE_TICK_O
  ) else begin
    $error("ticks back to back");
  end

  div_clear_a: assert property ( // RQ6
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    div_wr |=> ((pre_cnt == 6'h00) && (rate_timer == $past(bus.wdata)) && !RATE_TICK_O)
  ) else begin
    $error("divisor write did not clear timer");
  end

  sync_hs_a: assert property ( // RQ4
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    xmt_ctl[BRG_XMT_SYNC_BIT] |-> (pre_limit == BRG_PRE_SYNC)
  ) else begin
    $error("sync uses high speed bit");
  end

  async_hs_a: assert property ( // RQ3
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    !xmt_ctl[BRG_XMT_SYNC_BIT] |-> (pre_limit == (xmt_ctl[BRG_XMT_HS_BIT] ? BRG_PRE_ASYNC_HIGH : BRG_PRE_ASYNC_LOW))
  ) else begin
    $error("async multiplier wrong");
  end

  timer_range_a: assert property ( // RQ1
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (!div_wr && !$past(div_wr) && $stable(divisor)) |-> (rate_timer <= divisor)
  ) else begin
    $error("timer above divisor");
  end

  tick_gap_a: assert property ( // RQ5
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (settled && !RATE_TICK_O) |-> (gap < period)
  ) else begin
    $error("tick late");
  end

  free_run_a: assert property ( // RQ2
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (!div_wr && !pre_end) |=> (pre_cnt == $past(pre_cnt) + 6'h01)
  ) else begin
    $error("prescaler stalled");
  end

  reload_a: assert property ( // RQ8
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (pre_end && (rate_timer == 8'h00) && !div_wr) |=> (RATE_TICK_O && (rate_timer == $past(divisor)))
  ) else begin
    $error("no reload");
  end

  read_data_a: assert property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (bus.rd && (bus.addr == BRG_ADDR_DIVISOR) && !bus.wr) |=> (RDATA_O == $past(divisor))
  ) else begin
    $error("bad divisor read");
  end

  tick_source_a: assert property ( // RQ8
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    RATE_TICK_O |-> ($past(pre_end) && ($past(rate_timer) == 8'h00) && !$past(div_wr))
  ) else begin
    $error("tick without timer underflow");
  end

  timer_step_a: assert property ( // RQ2
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (pre_end && !div_wr && (rate_timer != 8'h00)) |=> (rate_timer == $past(rate_timer) - 8'h01)
  ) else begin
    $error("timer missed a step");
  end

  timer_hold_a: assert property ( // RQ8
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (!pre_end && !div_wr) |=> $stable(rate_timer)
  ) else begin
    $error("timer moved between prescaled steps");
  end

  tick_count_a: assert property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    RATE_TICK_O |=> (tick_count == $past(tick_count) + 8'h01)
  ) else begin
    $error("tick count missed a tick");
  end

  read_idle_a: assert property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    !bus.rd |=> (RDATA_O == 8'h00)
  ) else begin
    $error("read data outside read cycle");
  end

  xmt_fixed_a: assert property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    (xmt_ctl[BRG_XMT_UNIMP] == 1'b0)
  ) else begin
    $error("unimplemented control bit set");
  end

  sync_tick_c: cover property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    RATE_TICK_O && SYNC_MODE_O
  );
  high_tick_c: cover property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    RATE_TICK_O && (mode == BRG_MODE_ASYNC_HIGH)
  );
  low_tick_c: cover property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    RATE_TICK_O && (mode == BRG_MODE_ASYNC_LOW)
  );
  rewrite_c: cover property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    div_wr && (rate_timer != 8'h00)
  );
  mode_swap_c: cover property (
    @(posedge CLOCK_I) disable iff (RST_I || !live)
    xmt_wr && (gap != 16'h0000)
  );

endmodule : brg_rate_gen
`default_nettype wire

// ===== design/brg_pkg.sv
// Package for the serial rate generator: register map, fields, resets, timing
package brg_pkg;
  // Register indices (no offsets printed, chosen locally)
  localparam logic [1:0] BRG_ADDR_RCV_CTL  = 2'h0;
  localparam logic [1:0] BRG_ADDR_DIVISOR  = 2'h1;
  localparam logic [1:0] BRG_ADDR_XMT_CTL  = 2'h2;
  localparam logic [1:0] BRG_ADDR_TICKCNT  = 2'h3;

  // Reset values
  localparam logic [7:0] BRG_RST_RCV_CTL   = 8'h00;
  localparam logic [7:0] BRG_RST_DIVISOR   = 8'h00;
  localparam logic [7:0] BRG_RST_XMT_CTL   = 8'h02;

  // Transmit control field positions
  localparam int BRG_XMT_SYNC_BIT = 4;
  localparam int BRG_XMT_HS_BIT   = 2;
  localparam int BRG_XMT_UNIMP    = 3;

  // Prescale factors per mode, as counts of the oscillator clock
  localparam logic [5:0] BRG_PRE_ASYNC_LOW  = 6'h3f; // 64 - 1
  localparam logic [5:0] BRG_PRE_ASYNC_HIGH = 6'h0f; // 16 - 1
  localparam logic [5:0] BRG_PRE_SYNC       = 6'h03; // 4 - 1

  typedef enum logic [1:0] {
    BRG_MODE_ASYNC_LOW,
    BRG_MODE_ASYNC_HIGH,
    BRG_MODE_SYNC
  } brg_mode_e;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } brg_bus_s;
endpackage : brg_pkg

// ===== verif/brg_tick_sink.sv
// Partner model: serial shift logic consuming rate ticks
`timescale 1ns/1ps
`default_nettype none
module brg_tick_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tick_i,
  output logic      [15:0] gap_o
);
  logic [15:0] since;
  // Shift logic only needs the spacing of ticks, so phase is left to the bench
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      since <= 16'h0001;
      gap_o <= 16'h0000;
    end else if (tick_i) begin
      since <= 16'h0001;
      gap_o <= since;
    end else begin
      since <= since + 16'h0001;
    end
  end
endmodule : brg_tick_sink
`default_nettype wire

// ===== verif/brg_rate_gen_tb.sv
// Testbench for the serial rate generator
`timescale 1ns/1ps
`default_nettype none
module brg_rate_gen_tb;
  import brg_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  addr = 2'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        sync_mode;
  logic        tick;
  logic [15:0] gap;
  int          n_errors = 0;
  int          tests_run = 0;
  always #5 clk = ~clk;
  brg_rate_gen uut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
                    .RDATA_O(rdata), .SYNC_MODE_O(sync_mode), .RATE_TICK_O(tick));
  brg_tick_sink sink (.clk_i(clk), .rst_i(rst), .tick_i(tick), .gap_o(gap));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", {8'h00, exp}, {8'h00, rdata});
    @(posedge clk);
    #1 chk("read idle", 16'h0000, {8'h00, rdata});
  endtask : rd_reg
  task automatic t_reset;
    chk("sync mode", 16'h0000, {15'h0000, sync_mode});
    rd_reg(BRG_ADDR_RCV_CTL, 8'h00);
    rd_reg(BRG_ADDR_DIVISOR, 8'h00);
    rd_reg(BRG_ADDR_XMT_CTL, 8'h02);
    // First tick is 64 clocks away, so no tick counted yet
    rd_reg(BRG_ADDR_TICKCNT, 8'h00);
    wr_reg(BRG_ADDR_RCV_CTL, 8'ha5);
    rd_reg(BRG_ADDR_RCV_CTL, 8'ha5);
    // Unimplemented bit reads low, status bit stays set
    wr_reg(BRG_ADDR_XMT_CTL, 8'hff);
    rd_reg(BRG_ADDR_XMT_CTL, 8'hf7);
    chk("sync mode", 16'h0001, {15'h0000, sync_mode});
    $display("test reset_values done");
  endtask : t_reset
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
      #1;
    end while (tick !== 1'b1 && c < 20000);
  endtask : wait_tick
  task automatic t_rate(input logic [7:0] ctl, input logic [7:0] n, input int p);
    int c;
    int e;
    e = (int'(n) + 1) * p;
    wr_reg(BRG_ADDR_XMT_CTL, ctl);
    // Divisor write lands mid-period of the previous setting
    wr_reg(BRG_ADDR_DIVISOR, n);
    wait_tick(c);
    chk("first tick", e[15:0], c[15:0]);
    wait_tick(c);
    chk("tick period", e[15:0], c[15:0]);
    @(posedge clk);
    #1 chk("sink gap", e[15:0], gap);
    chk("sync mode", {15'h0000, ctl[4]}, {15'h0000, sync_mode});
    $display("test rate ctl %h div %h done", ctl, n);
  endtask : t_rate
  task automatic t_rerun;
    int c;
    wr_reg(BRG_ADDR_XMT_CTL, 8'h14);
    wr_reg(BRG_ADDR_DIVISOR, 8'h07);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1 chk("sync mode in reset", 16'h0000, {15'h0000, sync_mode});
    chk("tick in reset", 16'h0000, {15'h0000, tick});
    @(posedge clk);
    rst <= 1'b0;
    // Divisor back to 0 at low speed: first tick 64 clocks after release
    wait_tick(c);
    chk("tick after reset", 16'h0040, c[15:0]);
    rd_reg(BRG_ADDR_RCV_CTL, 8'h00);
    rd_reg(BRG_ADDR_DIVISOR, 8'h00);
    rd_reg(BRG_ADDR_XMT_CTL, 8'h02);
    // Tick count is read-only; one tick seen since release
    wr_reg(BRG_ADDR_TICKCNT, 8'h5a);
    rd_reg(BRG_ADDR_TICKCNT, 8'h01);
    $display("test mid_run_reset done");
  endtask : t_rerun
  task automatic close_out;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_rate(8'h00, 8'h02, 64);
    t_rate(8'h04, 8'h02, 16);
    t_rate(8'h10, 8'h00, 4);
    t_rate(8'h14, 8'h05, 4);
    t_rate(8'h04, 8'hff, 16);
    t_rerun;
    close_out;
  end
  // Whole run needs about nine thousand cycles
  initial begin
    #500000;
    n_errors++;
    close_out;
  end
endmodule : brg_rate_gen_tb
`default_nettype wire
